/* File: bench/sdd_drive_model.sv */
/* sdd_drive_model: encoder and output-frequency stand-in for the drive.
   assumes the ramped command arrives on clk_sys. */
`timescale 1ns/1ns
module sdd_drive_model (
  // clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst,
  // command side
  input  wire logic signed [15:0] cmdSpeed,
  input  wire logic               lagMode,
  // measured speeds
  output logic signed [15:0]      feedbackSpeed,
  output logic signed [15:0]      freqSpeed
);
  logic [1:0] divCnt;
  // a lagging shaft moves every fourth cycle, so command and feedback part ways
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      divCnt        <= 2'h0;
      feedbackSpeed <= 16'sh0;
    end else begin
      divCnt <= divCnt + 2'h1;
      if (!lagMode || divCnt == 2'h0) begin
        feedbackSpeed <= cmdSpeed;
      end
    end
  end
  assign freqSpeed = feedbackSpeed;
endmodule // sdd_drive_model

/* File: bench/sdd_speed_detect_sva.sv */
/* sdd_speed_detect_sva: port assertions for the speed detect block.
   assumes it is bound to sdd_speed_detect, one clock domain. */
`timescale 1ns/1ns
module sdd_speed_detect_sva (
  // watched ports
  input wire logic               clk_sys,
  input wire logic               rst,
  input wire logic               regRead,
  input wire logic [31:0]        regRdData,
  input wire sdd_pkg::sdd_ctrl_t ctrlMode,
  input wire logic               encoderPresent,
  input wire logic               driveAlarm,
  input wire logic               driveStopTerminal,
  input wire logic signed [15:0] setSpeed,
  input wire logic signed [15:0] rampedCommand,
  input wire logic signed [15:0] feedbackSpeed,
  input wire logic               upToSpeedFlag,
  input wire logic [2:0]         commandSpeedDetect,
  input wire logic [2:0]         actualSpeedDetect,
  input wire logic [13:0]        displayValue,
  input wire logic               displayOverflow
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ==========================================================
  // sequences
  // stop pin passes a three-stage filter, so it must stand six edges
  sequence stopHeld; driveStopTerminal [*6]; endsequence
  sequence readDone; regRead ##1 !regRead; endsequence
  // ==========================================================
  // assertions
  alarm_gate_a: assert property (driveAlarm |=>
    (commandSpeedDetect == 3'h0 && actualSpeedDetect == 3'h0)) else $error("flag on in alarm");
  stop_gate_a: assert property (stopHeld |=>
    (commandSpeedDetect == 3'h0 && actualSpeedDetect == 3'h0)) else $error("flag on at stop");
  rd_release_a: assert property (readDone |=> regRdData == 32'h0) else $error("read data stays");
  su_cmd_a: assert property ((ctrlMode == sdd_pkg::CTRL_SPEED && !encoderPresent &&
    setSpeed == 16'sh0) |=> upToSpeedFlag == ($past(rampedCommand) == 16'sh0))
    else $error("up-to-speed wrong on command");
  su_enc_a: assert property ((ctrlMode == sdd_pkg::CTRL_SPEED && encoderPresent &&
    setSpeed == 16'sh0) |=> upToSpeedFlag == ($past(feedbackSpeed) == 16'sh0))
    else $error("up-to-speed wrong on feedback");
  disp_clamp_a: assert property (displayValue <= 14'h270F &&
    (displayOverflow -> displayValue == 14'h270F)) else $error("display not clamped");
  cmd_mode_a: assert property (ctrlMode inside {sdd_pkg::CTRL_TORQUE,
    sdd_pkg::CTRL_POSITION} |=> commandSpeedDetect == 3'h0) else $error("cmd flag in mode");
  vf_same_a: assert property (ctrlMode == sdd_pkg::CTRL_VF [*2] |->
    commandSpeedDetect == actualSpeedDetect) else $error("V/F flags differ");
endmodule // sdd_speed_detect_sva
bind sdd_speed_detect sdd_speed_detect_sva i_sdd_speed_detect_sva (.clk_sys(clk_sys),
  .rst(rst), .regRead(regRead), .regRdData(regRdData), .ctrlMode(ctrlMode),
  .encoderPresent(encoderPresent), .driveAlarm(driveAlarm), .setSpeed(setSpeed),
  .driveStopTerminal(driveStopTerminal), .rampedCommand(rampedCommand),
  .feedbackSpeed(feedbackSpeed), .upToSpeedFlag(upToSpeedFlag), .displayValue(displayValue),
  .commandSpeedDetect(commandSpeedDetect), .actualSpeedDetect(actualSpeedDetect),
  .displayOverflow(displayOverflow));

/* File: bench/sdd_speed_detect_test.sv */
/* sdd_speed_detect_test: directed bench for the speed detect block.
   assumes the drive model supplies encoder and frequency speeds. */
`timescale 1ns/1ns
module sdd_speed_detect_test;
  // ==========================================================
  // signals
  logic               clk_sys = 1'b0;
  logic               rst, regWrite, regRead, driveAlarm, encoderPresent, lagMode;
  logic               startPin, driveStopTerminal, clearTerminal, upToSpeedFlag;
  logic               displayOverflow, digitalOut1, digitalOut2, digitalOut3, relayOut;
  logic [7:0]         regAddr;
  logic [31:0]        regWrData, regRdData;
  logic [2:0]         cmdDet, actDet;
  logic [13:0]        displayValue;
  logic signed [15:0] setSpeed, rampedCommand, feedbackSpeed, freqSpeed;
  sdd_pkg::sdd_ctrl_t ctrlMode;
  int                 error_cnt = 0, samples_checked = 0, cycles = 0;
  always #5 clk_sys = ~clk_sys;
  sdd_drive_model i_sdd_drive_model (.clk_sys(clk_sys), .rst(rst), .cmdSpeed(rampedCommand),
    .lagMode(lagMode), .feedbackSpeed(feedbackSpeed), .freqSpeed(freqSpeed));
  sdd_speed_detect i_sdd_speed_detect (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .ctrlMode(ctrlMode), .encoderPresent(encoderPresent), .driveAlarm(driveAlarm),
    .motorPoles(4'h4), .setSpeed(setSpeed), .rampedCommand(rampedCommand),
    .feedbackSpeed(feedbackSpeed), .freqSpeed(freqSpeed), .startPin(startPin),
    .driveStopTerminal(driveStopTerminal), .clearTerminal(clearTerminal),
    .upToSpeedFlag(upToSpeedFlag), .commandSpeedDetect(cmdDet), .actualSpeedDetect(actDet),
    .digitalOut1(digitalOut1), .digitalOut2(digitalOut2), .digitalOut3(digitalOut3),
    .relayContactTerminal(relayOut), .displayValue(displayValue),
    .displayOverflow(displayOverflow), .runSpeedUnit(), .freqMonitorUnit(), .settingUnit(),
    .speedSetpoint(), .vfFrequency());
  // ==========================================================
  // shared tasks
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %0h seen %0h", what, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regAddr   <= a;
    regWrData <= d;
    regWrite  <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    @(negedge clk_sys);
    chk("regRdData", e, regRdData);
  endtask
  task automatic spd(input logic signed [15:0] v, input int n);
    @(posedge clk_sys);
    rampedCommand <= v;
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic flg(input logic [2:0] e);
    chk("commandSpeedDetect", {29'h0, e}, {29'h0, cmdDet});
    chk("actualSpeedDetect", {29'h0, e}, {29'h0, actDet});
  endtask
  // ==========================================================
  // scenarios
  task automatic t_defaults();
    rdc(sdd_pkg::ADDR_THR1, 32'd300);
    rdc(sdd_pkg::ADDR_THR2, 32'd750);
    rdc(sdd_pkg::ADDR_THR3, 32'd1500);
    rdc(sdd_pkg::ADDR_REV1, 32'd9999);
    rdc(sdd_pkg::ADDR_BAND, 32'd10);
    rdc(8'hFC, 32'h0);
    $display("t_defaults done");
  endtask
  task automatic t_levels();
    wr(sdd_pkg::ADDR_THR2, 32'd1000);
    spd(16'sd999, 3); flg(3'b001);
    spd(16'sd1000, 3); flg(3'b011);
    spd(-16'sd1500, 3); flg(3'b111);
    spd(16'sd299, 3); flg(3'b000);
    wr(sdd_pkg::ADDR_REV1, 32'd200);
    spd(-16'sd250, 3); flg(3'b001);
    spd(16'sd250, 3); flg(3'b000);
    wr(sdd_pkg::ADDR_REV1, 32'd9999);
    spd(-16'sd250, 3); flg(3'b000);
    $display("t_levels done");
  endtask
  task automatic t_modes();
    ctrlMode <= sdd_pkg::CTRL_TORQUE;
    spd(16'sd1600, 3); chk("cmdDet", 32'h0, {29'h0, cmdDet});
    ctrlMode <= sdd_pkg::CTRL_POSITION;
    spd(16'sd1600, 3); chk("actDet", 32'h7, {29'h0, actDet});
    lagMode  <= 1'b1;
    ctrlMode <= sdd_pkg::CTRL_VF;
    spd(16'sd200, 8); flg(3'b000);
    lagMode  <= 1'b0;
    ctrlMode <= sdd_pkg::CTRL_SPEED;
    $display("t_modes done");
  endtask
  task automatic t_gates();
    spd(16'sd1600, 3); flg(3'b111);
    driveAlarm <= 1'b1;
    spd(16'sd1600, 2); flg(3'b000);
    driveAlarm        <= 1'b0;
    driveStopTerminal <= 1'b1;
    spd(16'sd1600, 8); flg(3'b000);
    driveStopTerminal <= 1'b0;
    clearTerminal     <= 1'b1;
    spd(16'sd1600, 8); flg(3'b000);
    clearTerminal <= 1'b0;
    wr(sdd_pkg::ADDR_THR1, 32'd0);
    startPin <= 1'b1;
    spd(16'sd0, 8); chk("cmdDet0", 32'h1, {31'h0, cmdDet[0]});
    startPin       <= 1'b0;
    encoderPresent <= 1'b1;
    spd(16'sd0, 8); chk("cmdDet0", 32'h0, {31'h0, cmdDet[0]});
    encoderPresent <= 1'b0;
    wr(sdd_pkg::ADDR_THR1, 32'd300);
    $display("t_gates done");
  endtask
  task automatic t_route();
    setSpeed <= 16'sd1000;
    spd(16'sd850, 3); chk("su", 32'h0, {31'h0, digitalOut2});
    spd(16'sd900, 4); chk("su", 32'h1, {31'h0, digitalOut2});
    chk("do3", 32'h1, {31'h0, digitalOut3});
    chk("do1", 32'h1, {31'h0, digitalOut1});
    wr(sdd_pkg::ADDR_TERMSEL, 32'h1003);
    spd(16'sd1000, 4); chk("relay", 32'h1, {31'h0, relayOut});
    chk("do1", 32'h1, {31'h0, digitalOut1});
    chk("do2", 32'h0, {31'h0, digitalOut2});
    $display("t_route done");
  endtask
  task automatic t_display();
    wr(sdd_pkg::ADDR_REFSPD, 32'd1800);
    wr(sdd_pkg::ADDR_SCALE, 32'd1000);
    spd(16'sd900, 4); chk("displayValue", 32'd500, {18'h0, displayValue});
    wr(sdd_pkg::ADDR_SCALE, 32'd9998);
    wr(sdd_pkg::ADDR_REFSPD, 32'd1);
    spd(16'sd900, 4); chk("displayOverflow", 32'h1, {31'h0, displayOverflow});
    wr(sdd_pkg::ADDR_SCALE, 32'd0);
    wr(sdd_pkg::ADDR_POLES, 32'd2);
    spd(16'sd900, 4); chk("displayValue", 32'd1500, {18'h0, displayValue});
    $display("t_display done");
  endtask
  // ==========================================================
  // run control
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end
  initial begin
    {rst, regWrite, regRead, driveAlarm, encoderPresent, lagMode} = 6'b100000;
    {startPin, driveStopTerminal, clearTerminal, regAddr, regWrData} = '0;
    {setSpeed, rampedCommand} = '0;
    ctrlMode = sdd_pkg::CTRL_SPEED;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    t_defaults();
    t_levels();
    t_modes();
    t_gates();
    t_route();
    t_display();
    end_of_test();
  end
endmodule // sdd_speed_detect_test

/* File: src/sdd_pkg.sv */
/*
  sdd_pkg: constants shared by the speed detect and display block.
  assumes a 100 MHz system clock and a plain strobe register port.
*/
package sdd_pkg;
  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] ADDR_SCALE   = 8'h00;
  localparam logic [7:0] ADDR_POLES   = 8'h04;
  localparam logic [7:0] ADDR_REFSPD  = 8'h08;
  localparam logic [7:0] ADDR_BAND    = 8'h0C;
  localparam logic [7:0] ADDR_THR1    = 8'h10;
  localparam logic [7:0] ADDR_REV1    = 8'h14;
  localparam logic [7:0] ADDR_THR2    = 8'h18;
  localparam logic [7:0] ADDR_THR3    = 8'h1C;
  localparam logic [7:0] ADDR_TERMSEL = 8'h20;
  localparam logic [7:0] ADDR_STATUS  = 8'h24;
  localparam logic [7:0] ADDR_DISPLAY = 8'h28;
  localparam logic [7:0] ADDR_SETTING = 8'h2C;
  localparam logic [7:0] ADDR_SETSPD  = 8'h30;
  // ==========================================================
  // reset values and limits
  localparam logic [13:0] RST_SCALE   = 14'h0000;
  localparam logic [13:0] MAX_SCALE   = 14'h270E;  // 9998
  localparam logic [3:0]  RST_POLES   = 4'h0;
  localparam logic [3:0]  MAX_POLES   = 4'hA;      // 10
  localparam logic [11:0] RST_REFSPD  = 12'h5DC;   // 1500 r/min
  localparam logic [11:0] MAX_SPEED   = 12'hE10;   // 3600 r/min
  localparam logic [6:0]  RST_BAND    = 7'h0A;     // 10 %
  localparam logic [6:0]  MAX_BAND    = 7'h64;     // 100 %
  localparam logic [11:0] RST_THR1    = 12'h12C;   // 300 r/min
  localparam logic [13:0] REV_UNUSED  = 14'h270F;  // 9999 sentinel
  localparam logic [11:0] RST_THR2    = 12'h2EE;   // 750 r/min
  localparam logic [11:0] RST_THR3    = 12'h5DC;   // 1500 r/min
  localparam logic [13:0] DISP_MAX    = 14'h270F;  // 9999
  localparam logic [15:0] RST_SETTING = 16'h0000;
  // terminal select: DO1 cmd1, DO2 up-to-speed, DO3 act1, relay none
  localparam logic [15:0] RST_TERMSEL = 16'h0512;
  // ==========================================================
  // conversion figures
  localparam logic [31:0] SYNC_FACTOR = 32'h0000_0078;  // 120 * f / p
  localparam logic [31:0] HZ_SCALE    = 32'h0000_0064;  // 0.01 Hz steps
  localparam logic [31:0] STEP_SCALE  = 32'h0000_000A;  // 0.1 r/min steps
  // ==========================================================
  // enumerations
  typedef enum logic [3:0] {
    CTRL_SPEED    = 4'b0001,
    CTRL_TORQUE   = 4'b0010,
    CTRL_POSITION = 4'b0100,
    CTRL_VF       = 4'b1000
  } sdd_ctrl_t;
  typedef enum logic [1:0] {
    UNIT_RPM     = 2'h0,
    UNIT_HZ_DISP = 2'h1,
    UNIT_MACHINE = 2'h2,
    UNIT_HZ_MOT  = 2'h3
  } sdd_unit_t;
  // terminal function codes
  localparam logic [3:0] FN_NONE = 4'h0;
  localparam logic [3:0] FN_SU   = 4'h1;
  localparam logic [3:0] FN_CMD1 = 4'h2;
  localparam logic [3:0] FN_ACT1 = 4'h5;
  localparam logic [3:0] FN_LAST = 4'h7;
endpackage

/* File: src/sdd_speed_detect.sv */
/*
  sdd_speed_detect: speed supervision flags, output terminal routing and
  four-digit monitor scaling of a motor drive.
  assumes speeds arrive signed in r/min from logic on clk_sys, and that
  stop, clear and start come from pins and must be synchronised here.
*/
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
module sdd_speed_detect (
  // clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst,
  // register port
  input  wire logic [7:0]         regAddr,
  input  wire logic [31:0]        regWrData,
  input  wire logic               regWrite,
  input  wire logic               regRead,
  output logic      [31:0]        regRdData,
  // drive state, same clock
  input  wire sdd_pkg::sdd_ctrl_t ctrlMode,
  input  wire logic               encoderPresent,
  input  wire logic               driveAlarm,
  input  wire logic [3:0]         motorPoles,
  input  wire logic signed [15:0] setSpeed,
  input  wire logic signed [15:0] rampedCommand,
  input  wire logic signed [15:0] feedbackSpeed,
  input  wire logic signed [15:0] freqSpeed,
  // pins
  input  wire logic               startPin,
  input  wire logic               driveStopTerminal,
  input  wire logic               clearTerminal,
  // flags and terminals
  output logic                    upToSpeedFlag,
  output logic [2:0]              commandSpeedDetect,
  output logic [2:0]              actualSpeedDetect,
  output logic                    digitalOut1,
  output logic                    digitalOut2,
  output logic                    digitalOut3,
  output logic                    relayContactTerminal,
  // monitor and setting outputs
  output logic [13:0]             displayValue,
  output logic                    displayOverflow,
  output sdd_pkg::sdd_unit_t      runSpeedUnit,
  output sdd_pkg::sdd_unit_t      freqMonitorUnit,
  output sdd_pkg::sdd_unit_t      settingUnit,
  output logic [15:0]             speedSetpoint,
  output logic [15:0]             vfFrequency
);
  // ==========================================================
  // state
  typedef struct packed {
    logic [13:0] scale;
    logic [3:0]  poles;
    logic [11:0] refSpeed;
    logic [6:0]  band;
    logic [11:0] thr1;
    logic [13:0] rev1;
    logic [11:0] thr2;
    logic [11:0] thr3;
    logic [15:0] termSel;
    logic [15:0] setting;
    logic [15:0] setpoint;
    logic [15:0] vfFreq;
    logic [2:0]  stopSync;
    logic [2:0]  clrSync;
    logic [2:0]  startSync;
    logic        stopLvl;
    logic        clrLvl;
    logic        startLvl;
    logic        su;
    logic [2:0]  cmdDet;
    logic [2:0]  actDet;
    logic [3:0]  termOut;
    logic [13:0] disp;
    logic        dispOver;
    logic [31:0] rdData;
  } sdd_state_t;
  sdd_state_t stateReg;
  sdd_state_t stateNext;
  // ==========================================================
  // helpers
  function automatic logic [15:0] sdd_mag(input logic signed [15:0] s);
    sdd_mag = s[15] ? 16'(-s) : 16'(s);
  endfunction
  function automatic logic sdd_det(input logic [15:0] mag, input logic [11:0] thr,
                                   input logic start);
    if (thr == 12'h000) begin
      sdd_det = start;
    end else begin
      sdd_det = (mag >= {4'h0, thr});
    end
  endfunction
  function automatic logic [31:0] sdd_rdiv(input logic [31:0] num, input logic [31:0] den);
    sdd_rdiv = (den == 32'h0) ? 32'h0 : (num + (den >> 1)) / den;
  endfunction
  function automatic logic sdd_pole_ok(input logic [3:0] p);
    sdd_pole_ok = (p <= sdd_pkg::MAX_POLES) && !p[0];
  endfunction
  // ==========================================================
  // combinational next state
  logic               isVf;
  logic               blockFlags;
  logic signed [15:0] cmdSrc;
  logic signed [15:0] actSrc;
  logic signed [15:0] suSrc;
  logic [15:0]        cmdMag;
  logic [15:0]        actMag;
  logic [15:0]        suMag;
  logic [15:0]        tgtMag;
  logic [15:0]        monMag;
  logic [15:0]        diff;
  logic [31:0]        bandWidth;
  logic [11:0]        thr1Cmd;
  logic [11:0]        thr1Act;
  logic [31:0]        dispCalc;
  logic [31:0]        setCalc;
  logic [6:0]         flagVec;
  logic               useHzSet;
  always_comb begin
    stateNext = stateReg;
    isVf      = (ctrlMode == sdd_pkg::CTRL_VF);
    // ==========================================================
    // pin synchronisers: a level counts once stages two and three agree
    stateNext.stopSync  = {stateReg.stopSync[1:0], driveStopTerminal};
    stateNext.clrSync   = {stateReg.clrSync[1:0], clearTerminal};
    stateNext.startSync = {stateReg.startSync[1:0], startPin};
    if (stateReg.stopSync[1] == stateReg.stopSync[2]) begin
      stateNext.stopLvl = stateReg.stopSync[2];
    end
    if (stateReg.clrSync[1] == stateReg.clrSync[2]) begin
      stateNext.clrLvl = stateReg.clrSync[2];
    end
    if (stateReg.startSync[1] == stateReg.startSync[2]) begin
      stateNext.startLvl = stateReg.startSync[2];
    end
    blockFlags = driveAlarm || stateReg.stopLvl || stateReg.clrLvl;
    // ==========================================================
    // speed detection
    cmdSrc = isVf ? freqSpeed : rampedCommand;
    actSrc = isVf ? freqSpeed : feedbackSpeed;
    cmdMag = sdd_mag(cmdSrc);
    actMag = sdd_mag(actSrc);
    // reverse sign selects the reverse threshold unless it is the sentinel
    thr1Cmd = (cmdSrc[15] && stateReg.rev1 != sdd_pkg::REV_UNUSED)
              ? stateReg.rev1[11:0] : stateReg.thr1;
    thr1Act = (actSrc[15] && stateReg.rev1 != sdd_pkg::REV_UNUSED)
              ? stateReg.rev1[11:0] : stateReg.thr1;
    stateNext.cmdDet[0] = sdd_det(cmdMag, thr1Cmd, stateReg.startLvl);
    stateNext.cmdDet[1] = sdd_det(cmdMag, stateReg.thr2, stateReg.startLvl);
    stateNext.cmdDet[2] = sdd_det(cmdMag, stateReg.thr3, stateReg.startLvl);
    stateNext.actDet[0] = sdd_det(actMag, thr1Act, stateReg.startLvl);
    stateNext.actDet[1] = sdd_det(actMag, stateReg.thr2, stateReg.startLvl);
    stateNext.actDet[2] = sdd_det(actMag, stateReg.thr3, stateReg.startLvl);
    if (!(ctrlMode == sdd_pkg::CTRL_SPEED || isVf)) begin
      stateNext.cmdDet = 3'h0;
    end
    if (blockFlags) begin
      stateNext.cmdDet = 3'h0;
      stateNext.actDet = 3'h0;
    end
    // ==========================================================
    // up-to-speed: band is a share of the set speed, both sides
    if (ctrlMode == sdd_pkg::CTRL_SPEED && encoderPresent) begin
      suSrc = feedbackSpeed;
    end else if (isVf) begin
      suSrc = freqSpeed;
    end else begin
      suSrc = rampedCommand;
    end
    suMag     = sdd_mag(suSrc);
    tgtMag    = sdd_mag(setSpeed);
    diff      = (suMag >= tgtMag) ? 16'(suMag - tgtMag) : 16'(tgtMag - suMag);
    bandWidth = ({16'h0, tgtMag} * {25'h0, stateReg.band}) / sdd_pkg::HZ_SCALE;
    stateNext.su = ({16'h0, diff} <= bandWidth);
    // ==========================================================
    // terminal routing, one selector nibble per terminal
    flagVec = {stateReg.actDet, stateReg.cmdDet, stateReg.su};
    for (int t = 0; t < 4; t++) begin
      if (stateReg.termSel[4*t +: 4] == sdd_pkg::FN_NONE ||
          stateReg.termSel[4*t +: 4] > sdd_pkg::FN_LAST) begin
        stateNext.termOut[t] = 1'b0;
      end else begin
        stateNext.termOut[t] = flagVec[3'(stateReg.termSel[4*t +: 4] - 4'h1)];
      end
    end

    // ==========================================================
    // monitor scaling
    monMag = isVf ? sdd_mag(freqSpeed) : sdd_mag(feedbackSpeed);
    if (stateReg.scale != 14'h0000) begin
      dispCalc = ({16'h0, monMag} * {18'h0, stateReg.scale})
                 / {20'h0, stateReg.refSpeed};
    end else if (stateReg.poles != 4'h0) begin
      dispCalc = ({16'h0, monMag} * {28'h0, stateReg.poles} * sdd_pkg::HZ_SCALE)
                 / sdd_pkg::SYNC_FACTOR;
    end else begin
      dispCalc = {16'h0, monMag};
    end
    stateNext.dispOver = (dispCalc > {18'h0, sdd_pkg::DISP_MAX});
    stateNext.disp     = stateNext.dispOver ? sdd_pkg::DISP_MAX : dispCalc[13:0];

    // ==========================================================
    // speed setting converted to r/min in 0.1 r/min steps
    useHzSet = (stateReg.scale == 14'h0000) && (stateReg.poles != 4'h0);
    if (useHzSet) begin
      // setting in 0.01 Hz, synchronous speed from display poles
      setCalc = sdd_rdiv({16'h0, stateReg.setting} * sdd_pkg::SYNC_FACTOR
                         * sdd_pkg::STEP_SCALE,
                         {28'h0, stateReg.poles} * sdd_pkg::HZ_SCALE);
    end else if (stateReg.scale != 14'h0000 && stateReg.poles != 4'h0) begin
      setCalc = sdd_rdiv({16'h0, stateReg.setting} * {20'h0, stateReg.refSpeed}
                         * sdd_pkg::STEP_SCALE, {18'h0, stateReg.scale});
    end else begin
      setCalc = {16'h0, stateReg.setting} * sdd_pkg::STEP_SCALE;
    end
    stateNext.setpoint = (setCalc > 32'h0000_FFFF) ? 16'hFFFF : setCalc[15:0];
    // V/F output frequency in 0.01 Hz from the motor poles
    setCalc = sdd_rdiv({16'h0, stateReg.setpoint} * {28'h0, motorPoles} * sdd_pkg::HZ_SCALE,
                       sdd_pkg::SYNC_FACTOR * sdd_pkg::STEP_SCALE);
    stateNext.vfFreq = (setCalc > 32'h0000_FFFF) ? 16'hFFFF : setCalc[15:0];

    // ==========================================================
    // register writes; out-of-range values are ignored, except terminal select and setting, which keep bits 15:0
    if (regWrite) begin
      case (regAddr)
        sdd_pkg::ADDR_SCALE: begin
          if (regWrData[31:0] <= {18'h0, sdd_pkg::MAX_SCALE}) begin
            stateNext.scale = regWrData[13:0];
          end
        end
        sdd_pkg::ADDR_POLES: begin
          if (regWrData[31:4] == 28'h0 && sdd_pole_ok(regWrData[3:0])) begin
            stateNext.poles = regWrData[3:0];
          end
        end
        sdd_pkg::ADDR_REFSPD: begin
          if (regWrData != 32'h0 && regWrData <= {20'h0, sdd_pkg::MAX_SPEED}) begin
            stateNext.refSpeed = regWrData[11:0];
          end
        end
        sdd_pkg::ADDR_BAND: begin
          if (regWrData <= {25'h0, sdd_pkg::MAX_BAND}) begin
            stateNext.band = regWrData[6:0];
          end
        end
        sdd_pkg::ADDR_THR1: begin
          if (regWrData <= {20'h0, sdd_pkg::MAX_SPEED}) begin
            stateNext.thr1 = regWrData[11:0];
          end
        end
        sdd_pkg::ADDR_REV1: begin
          if (regWrData <= {20'h0, sdd_pkg::MAX_SPEED} ||
              regWrData == {18'h0, sdd_pkg::REV_UNUSED}) begin
            stateNext.rev1 = regWrData[13:0];
          end
        end
        sdd_pkg::ADDR_THR2: begin
          if (regWrData <= {20'h0, sdd_pkg::MAX_SPEED}) begin
            stateNext.thr2 = regWrData[11:0];
          end
        end
        sdd_pkg::ADDR_THR3: begin
          if (regWrData <= {20'h0, sdd_pkg::MAX_SPEED}) begin
            stateNext.thr3 = regWrData[11:0];
          end
        end
        sdd_pkg::ADDR_TERMSEL: stateNext.termSel = regWrData[15:0];
        sdd_pkg::ADDR_SETTING: stateNext.setting = regWrData[15:0];
        default: ;
      endcase
    end

    // ==========================================================
    // register reads, data valid the cycle after the strobe
    stateNext.rdData = 32'h0;
    if (regRead) begin
      case (regAddr)
        sdd_pkg::ADDR_SCALE:   stateNext.rdData = {18'h0, stateReg.scale};
        sdd_pkg::ADDR_POLES:   stateNext.rdData = {28'h0, stateReg.poles};
        sdd_pkg::ADDR_REFSPD:  stateNext.rdData = {20'h0, stateReg.refSpeed};
        sdd_pkg::ADDR_BAND:    stateNext.rdData = {25'h0, stateReg.band};
        sdd_pkg::ADDR_THR1:    stateNext.rdData = {20'h0, stateReg.thr1};
        sdd_pkg::ADDR_REV1:    stateNext.rdData = {18'h0, stateReg.rev1};
        sdd_pkg::ADDR_THR2:    stateNext.rdData = {20'h0, stateReg.thr2};
        sdd_pkg::ADDR_THR3:    stateNext.rdData = {20'h0, stateReg.thr3};
        sdd_pkg::ADDR_TERMSEL: stateNext.rdData = {16'h0, stateReg.termSel};
        sdd_pkg::ADDR_STATUS:  stateNext.rdData = {20'h0, stateReg.termOut,
                                                   stateReg.dispOver, flagVec};
        sdd_pkg::ADDR_DISPLAY: stateNext.rdData = {18'h0, stateReg.disp};
        sdd_pkg::ADDR_SETTING: stateNext.rdData = {16'h0, stateReg.setting};
        sdd_pkg::ADDR_SETSPD:  stateNext.rdData = {16'h0, stateReg.setpoint};
        default:               stateNext.rdData = 32'h0;
      endcase
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stateReg          <= '0;
      stateReg.scale    <= sdd_pkg::RST_SCALE;
      stateReg.poles    <= sdd_pkg::RST_POLES;
      stateReg.refSpeed <= sdd_pkg::RST_REFSPD;
      stateReg.band     <= sdd_pkg::RST_BAND;
      stateReg.thr1     <= sdd_pkg::RST_THR1;
      stateReg.rev1     <= sdd_pkg::REV_UNUSED;
      stateReg.thr2     <= sdd_pkg::RST_THR2;
      stateReg.thr3     <= sdd_pkg::RST_THR3;
      stateReg.termSel  <= sdd_pkg::RST_TERMSEL;
      stateReg.setting  <= sdd_pkg::RST_SETTING;
    end else begin
      stateReg <= stateNext;
    end
  end

  // ==========================================================
  // unit selection: a pure function of the two settings
  always_comb begin
    if (stateReg.scale != 14'h0000) begin
      runSpeedUnit    = sdd_pkg::UNIT_MACHINE;
      freqMonitorUnit = sdd_pkg::UNIT_HZ_MOT;
      settingUnit     = (stateReg.poles != 4'h0) ? sdd_pkg::UNIT_MACHINE : sdd_pkg::UNIT_RPM;
    end else if (stateReg.poles != 4'h0) begin
      runSpeedUnit    = sdd_pkg::UNIT_HZ_DISP;
      freqMonitorUnit = sdd_pkg::UNIT_HZ_DISP;
      settingUnit     = sdd_pkg::UNIT_HZ_DISP;
    end else begin
      runSpeedUnit    = sdd_pkg::UNIT_RPM;
      freqMonitorUnit = sdd_pkg::UNIT_HZ_MOT;
      settingUnit     = sdd_pkg::UNIT_RPM;
    end
  end

  assign regRdData            = stateReg.rdData;
  assign upToSpeedFlag        = stateReg.su;
  assign commandSpeedDetect   = stateReg.cmdDet;
  assign actualSpeedDetect    = stateReg.actDet;
  assign digitalOut1          = stateReg.termOut[0];
  assign digitalOut2          = stateReg.termOut[1];
  assign digitalOut3          = stateReg.termOut[2];
  assign relayContactTerminal = stateReg.termOut[3];
  assign displayValue         = stateReg.disp;
  assign displayOverflow      = stateReg.dispOver;
  assign speedSetpoint        = stateReg.setpoint;
  assign vfFrequency          = stateReg.vfFreq;
endmodule // sdd_speed_detect
